// [core/iocs_defs.vh]
// Constants for the programming-time pin clamp and configuration control block
`ifndef IOCS_DEFS_VH
`define IOCS_DEFS_VH

// Pin count and clamp encodings
`define IOCS_NPINS 8
`define IOCS_CLAMP_HIGH 2'h0
`define IOCS_CLAMP_LOW 2'h1
`define IOCS_CLAMP_TRI 2'h2
`define IOCS_CLAMP_HOLD 2'h3

// Register offsets (4-bit word index)
`define IOCS_REG_CTRL 4'h0
`define IOCS_REG_CLAMP 4'h1
`define IOCS_REG_STATUS 4'h2
`define IOCS_REG_FLASH_ADDR 4'h3
`define IOCS_REG_CFG_DATA 4'h4
`define IOCS_REG_USER_DATA 4'h5

// Control register bits
`define IOCS_CTRL_ENTER 0
`define IOCS_CTRL_EXIT 1
`define IOCS_CTRL_CLAMP_EN 2
`define IOCS_CTRL_RECONFIG 3
`define IOCS_CTRL_ERASE 4
`define IOCS_CTRL_SET_SEC 5
`define IOCS_CTRL_SET_DONE 6

// Status register bits
`define IOCS_ST_PROG 0
`define IOCS_ST_LOADING 1
`define IOCS_ST_USER 2
`define IOCS_ST_SECURE 3
`define IOCS_ST_DONE 4
`define IOCS_ST_PENDING 5
`define IOCS_ST_GUARD 6

// Configuration load time in microseconds, and clock rate in MHz
`define IOCS_LOAD_TIME_US 450
`define IOCS_CLK_MHZ 50
`define IOCS_LOAD_CYCLES (`IOCS_LOAD_TIME_US * `IOCS_CLK_MHZ)

// Readback of a protected array
`define IOCS_LOCKED_DATA 32'h00000000

`endif

// [core/iocs_sync2.v]
// Two-stage synchroniser for a bus of asynchronous level inputs
`timescale 1ns/1ps
module iocs_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg;

    always @(posedge mclk) begin
        if (srst) begin
            stage1_reg <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule

// [core/iocs_top.v]
// Pin clamp, reconfiguration, security and power-up output gating control
// Functional notes
// - Programming default: all pins tri-stated, pulled up
// - Clamp mode: per-pin high, low, tri, hold
// - Hold drives sampled output; inputs stay tri-stated
// - Flash updates while user design keeps running
// - New image loads at next power cycle
// - Reconfigure command, in user mode only, reloads volatile config, load time
// - Pins tri-stated, pulled up during reconfiguration
// - Security bit blocks config flash readback
// - Only erase or srst clears the security bit
// - No readout path for volatile configuration
// - User flash readable regardless of security
// - Supply-low guard forces all outputs off
// - Pins tri-stated until configuration load completes
// - Weak pull-ups enabled during configuration download
// - Outputs off when supply order or pad wrong
// - Outputs held off until completion bit programmed
// - Configuration load finishes within load time
// - Enter and exit steps bracket programming session
`timescale 1ns/1ps
`include "iocs_defs.vh"
module iocs_top (
    // Clock and reset (srst acts as power-on reset)
    input wire mclk,
    input wire srst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Asynchronous supply monitors
    input wire core_supply_low,
    input wire io_supply_low,
    input wire io_before_core,
    input wire pad_over_supply,
    // User logic pin requests
    input wire [`IOCS_NPINS-1:0] user_pin_out,
    input wire [`IOCS_NPINS-1:0] user_pin_oe,
    input wire [`IOCS_NPINS-1:0] pin_is_output,
    // Pads
    input wire [`IOCS_NPINS-1:0] pad_in,
    output reg [`IOCS_NPINS-1:0] pad_out,
    output reg [`IOCS_NPINS-1:0] pad_oe,
    output reg [`IOCS_NPINS-1:0] pad_pullup,
    // Configuration flash storage
    output reg [3:0] cfg_flash_addr,
    output reg [31:0] cfg_flash_wdata,
    output reg cfg_flash_wr,
    input wire [31:0] cfg_flash_rdata,
    // User flash storage
    input wire [31:0] user_flash_rdata,
    // Status
    output reg user_mode,
    output reg supply_low_guard
);
    localparam ST_LOAD = 2'h0;
    localparam ST_USER = 2'h1;
    localparam ST_PROG = 2'h2;

    localparam [31:0] LOAD_CYCLES = `IOCS_LOAD_CYCLES;

    reg [1:0] state_reg;
    reg [31:0] load_cnt_reg;
    reg clamp_en_reg;
    reg [2*`IOCS_NPINS-1:0] clamp_cfg_reg;
    reg [2*`IOCS_NPINS-1:0] clamp_lat_reg;
    reg [`IOCS_NPINS-1:0] hold_val_reg;
    reg secure_reg;
    reg done_reg;
    reg pending_reg;
    reg [3:0] faddr_reg;
    reg [`IOCS_NPINS-1:0] dir_lat_reg;
    reg [`IOCS_NPINS-1:0] pad_out_next;
    reg [`IOCS_NPINS-1:0] pad_oe_next;
    reg [`IOCS_NPINS-1:0] pad_pullup_next;
    reg [31:0] status_word;
    reg [31:0] rdata_next;
    wire [3:0] mon_sync;
    wire [`IOCS_NPINS-1:0] pad_sync;
    wire guard_now;
    wire ctrl_wr;
    wire cmd_enter;
    wire cmd_exit;
    wire cmd_reconfig;
    wire cmd_erase;
    wire cmd_set_sec;
    wire cmd_set_done;
    wire park_pins;
    wire [`IOCS_NPINS-1:0] drv_val;
    wire [`IOCS_NPINS-1:0] drv_oe;

    iocs_sync2 #(.WIDTH(4)) u_mon_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in({pad_over_supply, io_before_core, io_supply_low, core_supply_low}),
        .sync_out(mon_sync)
    );

    iocs_sync2 #(.WIDTH(`IOCS_NPINS)) u_pad_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    assign guard_now = |mon_sync;
    assign ctrl_wr = reg_wr && (reg_addr == `IOCS_REG_CTRL);
    // One write may carry several commands; each is decoded on its own
    assign cmd_enter = ctrl_wr && reg_wdata[`IOCS_CTRL_ENTER];
    assign cmd_exit = ctrl_wr && reg_wdata[`IOCS_CTRL_EXIT];
    assign cmd_reconfig = ctrl_wr && reg_wdata[`IOCS_CTRL_RECONFIG];
    assign cmd_erase = ctrl_wr && reg_wdata[`IOCS_CTRL_ERASE];
    assign cmd_set_sec = ctrl_wr && reg_wdata[`IOCS_CTRL_SET_SEC];
    assign cmd_set_done = ctrl_wr && reg_wdata[`IOCS_CTRL_SET_DONE];

    // Main control sequence
    always @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_LOAD;
            load_cnt_reg <= 32'h0;
            clamp_en_reg <= 1'b0;
            clamp_lat_reg <= {2*`IOCS_NPINS{1'b0}};
            hold_val_reg <= {`IOCS_NPINS{1'b0}};
            dir_lat_reg <= {`IOCS_NPINS{1'b0}};
            pending_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_LOAD: begin
                    // Load only counts with supplies good
                    if (guard_now) begin
                        load_cnt_reg <= 32'h0;
                    end else if (load_cnt_reg >= LOAD_CYCLES - 32'h1) begin
                        state_reg <= ST_USER;
                        load_cnt_reg <= 32'h0;
                        pending_reg <= 1'b0;
                    end else begin
                        load_cnt_reg <= load_cnt_reg + 32'h1;
                    end
                end
                ST_USER: begin
                    if (cmd_reconfig) begin
                        state_reg <= ST_LOAD;
                    end else if (cmd_enter) begin
                        state_reg <= ST_PROG;
                        clamp_en_reg <= reg_wdata[`IOCS_CTRL_CLAMP_EN];
                        clamp_lat_reg <= clamp_cfg_reg;
                        hold_val_reg <= user_pin_out & pin_is_output;
                        dir_lat_reg <= pin_is_output;
                    end
                    if (cfg_flash_wr) begin
                        pending_reg <= 1'b1;
                    end
                end
                ST_PROG: begin
                    if (cfg_flash_wr) begin
                        pending_reg <= 1'b1;
                    end
                    if (cmd_exit) begin
                        state_reg <= ST_USER;
                        clamp_en_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_LOAD;
                end
            endcase
        end
    end

    // Non-volatile bits: survive reconfiguration, cleared only by erase or srst
    always @(posedge mclk) begin
        if (srst) begin
            secure_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (cmd_erase) begin
            secure_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            if (cmd_set_sec) begin
                secure_reg <= 1'b1;
            end
            if (cmd_set_done) begin
                done_reg <= 1'b1;
            end
        end
    end

    // Clamp table and flash access; flash writes allowed while user runs
    always @(posedge mclk) begin
        if (srst) begin
            clamp_cfg_reg <= {2*`IOCS_NPINS{1'b0}};
            faddr_reg <= 4'h0;
            cfg_flash_addr <= 4'h0;
            cfg_flash_wdata <= 32'h0;
            cfg_flash_wr <= 1'b0;
        end else begin
            cfg_flash_wr <= 1'b0;
            if (reg_wr && reg_addr == `IOCS_REG_CLAMP) begin
                clamp_cfg_reg <= reg_wdata[2*`IOCS_NPINS-1:0];
            end
            if (reg_wr && reg_addr == `IOCS_REG_FLASH_ADDR) begin
                faddr_reg <= reg_wdata[3:0];
            end
            if (reg_wr && reg_addr == `IOCS_REG_CFG_DATA && state_reg != ST_LOAD) begin
                cfg_flash_wr <= 1'b1;
                cfg_flash_wdata <= reg_wdata;
            end
            cfg_flash_addr <= faddr_reg;
        end
    end

    // Per-pin programming-time values
    genvar gi;
    generate
        for (gi = 0; gi < `IOCS_NPINS; gi = gi + 1) begin : g_pin
            wire [1:0] sel = clamp_lat_reg[2*gi+1:2*gi];
            assign drv_oe[gi] = (sel == `IOCS_CLAMP_HIGH) || (sel == `IOCS_CLAMP_LOW) ||
                                ((sel == `IOCS_CLAMP_HOLD) && dir_lat_reg[gi]);
            assign drv_val[gi] = (sel == `IOCS_CLAMP_HIGH) ? 1'b1 :
                                 (sel == `IOCS_CLAMP_LOW) ? 1'b0 : hold_val_reg[gi];
        end
    endgenerate

    // Pad next values; any reason to park beats every other source
    assign park_pins = guard_now || !done_reg || (state_reg == ST_LOAD);

    always @* begin
        pad_oe_next = user_pin_oe;
        pad_out_next = user_pin_out;
        pad_pullup_next = {`IOCS_NPINS{1'b0}};
        if (park_pins) begin
            pad_oe_next = {`IOCS_NPINS{1'b0}};
            pad_out_next = {`IOCS_NPINS{1'b0}};
            pad_pullup_next = {`IOCS_NPINS{1'b1}};
        end else if (state_reg == ST_PROG && clamp_en_reg) begin
            pad_oe_next = drv_oe;
            pad_out_next = drv_val;
            pad_pullup_next = ~drv_oe;
        end else if (state_reg == ST_PROG) begin
            pad_oe_next = {`IOCS_NPINS{1'b0}};
            pad_out_next = {`IOCS_NPINS{1'b0}};
            pad_pullup_next = {`IOCS_NPINS{1'b1}};
        end
    end

    // Pad drive; registered so the pads never see decode glitches
    always @(posedge mclk) begin
        if (srst) begin
            pad_out <= {`IOCS_NPINS{1'b0}};
            pad_oe <= {`IOCS_NPINS{1'b0}};
            pad_pullup <= {`IOCS_NPINS{1'b1}};
            user_mode <= 1'b0;
            supply_low_guard <= 1'b1;
        end else begin
            supply_low_guard <= guard_now;
            user_mode <= (state_reg == ST_USER);
            pad_oe <= pad_oe_next;
            pad_out <= pad_out_next;
            pad_pullup <= pad_pullup_next;
        end
    end

    // Status word, one flag per bit
    always @* begin
        status_word = 32'h0;
        status_word[`IOCS_ST_PROG] = (state_reg == ST_PROG);
        status_word[`IOCS_ST_LOADING] = (state_reg == ST_LOAD);
        status_word[`IOCS_ST_USER] = (state_reg == ST_USER);
        status_word[`IOCS_ST_SECURE] = secure_reg;
        status_word[`IOCS_ST_DONE] = done_reg;
        status_word[`IOCS_ST_PENDING] = pending_reg;
        status_word[`IOCS_ST_GUARD] = guard_now;
    end

    // Read mux
    always @* begin
        rdata_next = 32'h0;
        case (reg_addr)
            `IOCS_REG_CLAMP: rdata_next = {16'h0, clamp_cfg_reg};
            `IOCS_REG_STATUS: rdata_next = status_word;
            `IOCS_REG_FLASH_ADDR: rdata_next = {28'h0, faddr_reg};
            // Locked array reads as zero
            `IOCS_REG_CFG_DATA: rdata_next = secure_reg ? `IOCS_LOCKED_DATA :
                                             cfg_flash_rdata;
            `IOCS_REG_USER_DATA: rdata_next = user_flash_rdata;
            // Volatile configuration has no address at all
            default: rdata_next = 32'h0;
        endcase
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    wire unused_pads = ^pad_sync;
endmodule

// [bench/iocs_top_sva.sv]
// Port-level assertions for the pin clamp and configuration control block
`timescale 1ns/1ps
`include "iocs_defs.vh"
module iocs_top_sva (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Supply monitors
    input wire core_supply_low,
    input wire io_before_core,
    input wire pad_over_supply,
    // Pads, flash and status
    input wire [`IOCS_NPINS-1:0] pad_oe,
    input wire [`IOCS_NPINS-1:0] pad_pullup,
    input wire [31:0] cfg_flash_wdata,
    input wire cfg_flash_wr,
    input wire user_mode,
    input wire supply_low_guard
);
    localparam int LOAD_MAX = `IOCS_LOAD_CYCLES + 10;
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (srst);
    // Only the first load is bounded; a programming session may last
    reg first_load_reg;
    reg [15:0] load_cnt_reg;
    always @(posedge mclk) begin
        if (srst) begin
            first_load_reg <= 1'b1;
            load_cnt_reg <= 16'h0;
        end else begin
            if (user_mode)
                first_load_reg <= 1'b0;
            if (first_load_reg && !supply_low_guard)
                load_cnt_reg <= load_cnt_reg + 16'h1;
        end
    end
    sequence reconfig_cmd;
        reg_wr && reg_addr == `IOCS_REG_CTRL && reg_wdata[`IOCS_CTRL_RECONFIG] && user_mode;
    endsequence
    sequence pins_parked;
        pad_oe == 8'h00 && pad_pullup == 8'hff;
    endsequence
    a_guard_off: assert property (supply_low_guard && $past(supply_low_guard) |-> pad_oe == 8'h00)
        else $error("outputs driven under supply guard");
    a_guard_rise: assert property (core_supply_low [*4] |-> supply_low_guard)
        else $error("supply guard missing");
    a_order_off: assert property (io_before_core [*5] |-> pad_oe == 8'h00)
        else $error("outputs driven with wrong supply order");
    a_pad_over: assert property (pad_over_supply [*5] |-> pad_oe == 8'h00)
        else $error("outputs driven with pad over supply");
    a_reset_park: assert property (disable iff (1'b0) srst |=> pins_parked and !user_mode)
        else $error("pins not parked after reset");
    a_load_bound: assert property (first_load_reg |-> load_cnt_reg < LOAD_MAX)
        else $error("configuration load too long");
    a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_flash_write: assert property (reg_wr && reg_addr == `IOCS_REG_CFG_DATA && user_mode
        |=> cfg_flash_wr && cfg_flash_wdata == $past(reg_wdata))
        else $error("flash write not issued");
    a_reconfig_park: assert property (reconfig_cmd |-> ##2 !user_mode ##0 pins_parked [*8])
        else $error("pins not parked in reconfiguration");
endmodule

// [bench/iocs_flash_model.sv]
// Behavioural storage behind the flash ports
`timescale 1ns/1ps
module iocs_flash_model (
    // Clock
    input wire mclk,
    // Configuration flash
    input wire [3:0] cfg_flash_addr,
    input wire [31:0] cfg_flash_wdata,
    input wire cfg_flash_wr,
    output wire [31:0] cfg_flash_rdata,
    // User flash
    output wire [31:0] user_flash_rdata
);
    reg [31:0] mem [0:15];
    integer i;
    initial begin
        for (i = 0; i < 16; i = i + 1)
            mem[i] = 32'hffffffff;
    end
    always @(posedge mclk) begin
        if (cfg_flash_wr)
            mem[cfg_flash_addr] <= cfg_flash_wdata;
    end
    assign cfg_flash_rdata = mem[cfg_flash_addr];
    // Never gated here; refusal is the device's job
    assign user_flash_rdata = 32'h5a5a0f0f;
endmodule

// [bench/testbench.sv]
// Self-checking bench for the pin clamp and configuration control block
`timescale 1ns/1ps
`include "iocs_defs.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    reg mclk = 1'b0;
    reg srst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [3:0] sup = 4'h0;
    reg [7:0] u_out = 8'h00;
    reg [7:0] u_oe = 8'h00;
    reg [7:0] u_dir = 8'h00;
    reg [7:0] p_in = 8'h00;
    reg rnd_on = 1'b1;
    reg rd_d = 1'b0;
    reg [31:0] e_rd;
    reg [31:0] exp_q[$];
    wire [31:0] reg_rdata, fw, fr, ur;
    wire [7:0] pad_out, pad_oe, pad_pullup;
    wire [3:0] fa;
    wire fwr, user_mode, guard;
    integer error_cnt = 0;
    integer samples_checked = 0;
    integer seed = 32'hd03c1df7;
    integer i;
    iocs_top iocs_top_inst (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_supply_low(sup[3]), .io_supply_low(sup[2]), .io_before_core(sup[1]),
        .pad_over_supply(sup[0]), .user_pin_out(u_out), .user_pin_oe(u_oe),
        .pin_is_output(u_dir), .pad_in(p_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .cfg_flash_addr(fa), .cfg_flash_wdata(fw),
        .cfg_flash_wr(fwr), .cfg_flash_rdata(fr), .user_flash_rdata(ur),
        .user_mode(user_mode), .supply_low_guard(guard));
    iocs_flash_model iocs_flash_model_inst (.mclk(mclk), .cfg_flash_addr(fa),
        .cfg_flash_wdata(fw), .cfg_flash_wr(fwr), .cfg_flash_rdata(fr),
        .user_flash_rdata(ur));
    initial begin
        forever #10 mclk = ~mclk;
    end
    task automatic step(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input [3:0] a, input [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        step(1);
        reg_wr <= 1'b0;
        step(1);
    endtask
    task automatic rd(input [3:0] a, input [31:0] e);
        exp_q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        step(1);
        reg_rd <= 1'b0;
        step(1);
    endtask
    task automatic wait_user;
        integer k;
        k = 0;
        while (user_mode !== 1'b1 && k < 23000) begin
            step(1);
            k++;
        end
        step(2);
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        if (rd_d) begin
            e_rd = exp_q.pop_front();
            `CHK(reg_rdata, e_rd)
        end
        if (rnd_on) begin
            u_out <= $random(seed);
            u_oe <= $random(seed);
            u_dir <= $random(seed);
            p_in <= $random(seed);
        end
    end
    initial begin
        step(8);
        srst <= 1'b0;
        step(1);
        `CHK(pad_pullup, 8'hff)
        wait_user();
        `CHK(user_mode, 1'b1)
        `CHK(pad_oe, 8'h00)
        wr(`IOCS_REG_CTRL, 32'h40);
        rnd_on <= 1'b0;
        step(1);
        for (i = 0; i < 4; i++) begin
            u_out <= $random(seed);
            u_oe <= $random(seed);
            step(3);
            `CHK(pad_oe, u_oe)
            `CHK(pad_out & pad_oe, u_out & u_oe)
        end
        wr(`IOCS_REG_FLASH_ADDR, 32'h3);
        wr(`IOCS_REG_CFG_DATA, 32'hc0de1234);
        rd(`IOCS_REG_CFG_DATA, 32'hc0de1234);
        rd(`IOCS_REG_STATUS, 32'h34);
        rd(4'hf, 32'h0);
        wr(`IOCS_REG_CTRL, 32'h20);
        rd(`IOCS_REG_CFG_DATA, `IOCS_LOCKED_DATA);
        rd(`IOCS_REG_USER_DATA, 32'h5a5a0f0f);
        wr(`IOCS_REG_CTRL, 32'h8);
        step(1);
        `CHK(pad_oe, 8'h00)
        step(22000);
        `CHK(user_mode, 1'b0)
        wait_user();
        rd(`IOCS_REG_CFG_DATA, `IOCS_LOCKED_DATA);
        wr(`IOCS_REG_FLASH_ADDR, 32'h5);
        wr(`IOCS_REG_CTRL, 32'h10);
        rd(`IOCS_REG_CFG_DATA, 32'hffffffff);
        // Pins 0..7: high, low, tri, hold out, hold out, hold in, high, low
        u_out <= 8'h08;
        u_dir <= 8'h18;
        wr(`IOCS_REG_CTRL, 32'h40);
        wr(`IOCS_REG_CLAMP, 32'h4fe4);
        wr(`IOCS_REG_CTRL, 32'h5);
        u_out <= 8'hf7;
        wr(`IOCS_REG_CLAMP, 32'h0);
        step(1);
        `CHK(pad_oe, 8'hdb)
        `CHK(pad_out & pad_oe, 8'h49)
        wr(`IOCS_REG_CTRL, 32'h2);
        step(1);
        `CHK(user_mode, 1'b1)
        u_oe <= 8'hff;
        wr(`IOCS_REG_CTRL, 32'h1);
        step(1);
        `CHK(pad_oe, 8'h00)
        `CHK(pad_pullup, 8'hff)
        wr(`IOCS_REG_CTRL, 32'h2);
        rd(`IOCS_REG_STATUS, 32'h14);
        for (i = 0; i < 4; i++) begin
            sup <= 4'h8 >> i;
            step(6);
            `CHK(pad_oe, 8'h00)
            `CHK(guard, 1'b1)
            sup <= 4'h0;
            step(2);
        end
        complete_run();
    end
    initial begin
        step(60000);
        error_cnt++;
        complete_run();
    end
endmodule
bind iocs_top iocs_top_sva iocs_top_sva_inst (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_supply_low(core_supply_low), .io_before_core(io_before_core),
    .pad_over_supply(pad_over_supply), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .cfg_flash_wdata(cfg_flash_wdata), .cfg_flash_wr(cfg_flash_wr),
    .user_mode(user_mode), .supply_low_guard(supply_low_guard));
